// ### src/bsp_pkg.sv
// constants and types shared by the barometric sensor serial port
package bsp_pkg;
    // command byte codes and field decode
    localparam logic [7:0] CMD_RESET = 8'h1e;
    localparam logic [7:0] CMD_RESULT = 8'h00;
    localparam logic [3:0] CMD_MEM_HI = 4'ha;
    localparam logic [2:0] CMD_CONV_HI = 3'h2;
    // i2c address: six fixed bits then the complement of chip select
    localparam logic [5:0] I2C_ADDR_HI = 6'h3b;
    // bit counter marks within one serial byte
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
    // oversampling: index 0..4 selects 256..4096 samples
    localparam int OSR_MIN = 256;
    localparam logic [2:0] OSR_MAX_IDX = 3'h4;
    // calibration memory and result sizes
    localparam int CAL_WORDS = 8;
    localparam int CAL_WIDTH = 16;
    localparam int RESULT_WIDTH = 24;
    localparam logic [7:0] CAL_PAD = 8'h00;
    localparam logic [23:0] RESULT_ZERO = 24'h000000;
    // pattern folded into a result whose conversion was disturbed
    localparam logic [23:0] CORRUPT_MASK = 24'h5a5a5a;
    localparam logic [23:0] TIMER_DONE = 24'h000001;
    localparam logic [23:0] TIMER_IDLE = 24'h000000;

    // command byte, most significant bit first on the wire
    typedef struct packed {
        logic memory_read_select_bit;
        logic conversion_select_bit;
        logic spare;
        logic temperature_sel;
        logic [2:0] field;
        logic stop;
    } bsp_cmd_type;

    // conversion status handed from the core to the link side
    typedef struct packed {
        logic busy;
        logic readable;
    } bsp_status_type;

    typedef enum logic [1:0] {
        LK_ADDR = 2'b00,
        LK_CMD = 2'b01,
        LK_SEND = 2'b11,
        LK_DONE = 2'b10
    } bsp_link_state_type;
endpackage : bsp_pkg

// ### src/bsp_serial_port.sv
// serial command port of the pressure/temperature sensor: spi or i2c link plus core
`timescale 1ns/100ps
module bsp_serial_port import bsp_pkg::*; #(
    parameter int CONV_CYCLES_PER_SAMPLE = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic chip_select_pin_n,
    input wire logic protocol_select_i2c,
    input wire logic [127:0] calib_fuse,
    input wire logic [23:0] raw_pressure_sample,
    input wire logic [23:0] raw_temperature_sample,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    output logic conv_busy,
    output logic conv_temperature
);

    // core domain
    logic proto_s1_reg;
    logic proto_s2_reg;
    logic csel_s1_reg;
    logic csel_s2_reg;
    logic i2c_mode_reg;
    logic addr_c_reg;
    logic cmd_s1_reg;
    logic cmd_s2_reg;
    logic cmd_s3_reg;
    logic busy_reg;
    logic avail_reg;
    logic corrupt_reg;
    logic kind_reg;
    logic readable_reg;
    logic [23:0] timer_reg;
    logic [23:0] result_reg;
    logic [CAL_WIDTH-1:0] calib_reg [CAL_WORDS];
    logic cmd_evt;
    logic finish;
    bsp_cmd_type core_cmd;
    logic is_reset;
    logic is_conv;
    logic is_read;
    logic [2:0] osr_idx;
    logic [23:0] conv_cycles;

    // link domain
    bsp_link_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] rx_reg;
    logic [23:0] tx_reg;
    logic ack_reg;
    logic start_tgl_reg;
    logic start_seen_reg;
    logic cmd_tgl_reg;
    logic [7:0] cmd_byte_reg;
    logic [23:0] held_word_reg;
    bsp_status_type stat_s1_reg;
    bsp_status_type stat_s2_reg;
    logic out_reg;
    logic oe_n_reg;
    logic link_clr;
    logic start_evt;
    logic [7:0] rx_byte;
    bsp_cmd_type rx_cmd;
    logic cmd_done;
    logic [23:0] cmd_word;
    logic addr_hit;
    logic drive_low;

    // straps: pins pass two flops, then held as quasi-static levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            proto_s1_reg <= 1'b0;
            proto_s2_reg <= 1'b0;
            csel_s1_reg <= 1'b1;
            csel_s2_reg <= 1'b1;
            i2c_mode_reg <= 1'b0;
            addr_c_reg <= 1'b0;
        end else begin
            proto_s1_reg <= protocol_select_i2c;
            proto_s2_reg <= proto_s1_reg;
            csel_s1_reg <= chip_select_pin_n;
            csel_s2_reg <= csel_s1_reg;
            i2c_mode_reg <= proto_s2_reg;
            addr_c_reg <= ~csel_s2_reg;
        end
    end

    // command toggle from the link: two sync flops, then an edge flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_s1_reg <= 1'b0;
            cmd_s2_reg <= 1'b0;
            cmd_s3_reg <= 1'b0;
        end else begin
            cmd_s1_reg <= cmd_tgl_reg;
            cmd_s2_reg <= cmd_s1_reg;
            cmd_s3_reg <= cmd_s2_reg;
        end
    end

    // the byte was written with the toggle and is stable by the time it arrives
    assign cmd_evt = cmd_s2_reg ^ cmd_s3_reg;
    assign core_cmd = bsp_cmd_type'(cmd_byte_reg);
    assign is_reset = cmd_evt && (cmd_byte_reg == CMD_RESET);
    assign is_read = cmd_evt && (cmd_byte_reg == CMD_RESULT);
    assign is_conv = cmd_evt && (cmd_byte_reg[7:5] == CMD_CONV_HI) && !core_cmd.stop;
    assign osr_idx = (core_cmd.field > OSR_MAX_IDX) ? OSR_MAX_IDX : core_cmd.field;
    assign conv_cycles = 24'(CONV_CYCLES_PER_SAMPLE * (OSR_MIN << osr_idx));
    assign finish = busy_reg && (timer_reg == TIMER_DONE);

    // conversion engine on the internal clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            avail_reg <= 1'b0;
            corrupt_reg <= 1'b0;
            kind_reg <= 1'b0;
            timer_reg <= TIMER_IDLE;
            result_reg <= RESULT_ZERO;
        end else if (is_reset) begin
            // reset command wins over anything else in flight
            busy_reg <= 1'b0;
            avail_reg <= 1'b0;
            corrupt_reg <= 1'b0;
            timer_reg <= TIMER_IDLE;
        end else begin
            if (busy_reg) begin
                timer_reg <= timer_reg - TIMER_DONE;
            end
            if (is_conv && busy_reg) begin
                corrupt_reg <= 1'b1;
            end else if (is_conv) begin
                busy_reg <= 1'b1;
                kind_reg <= core_cmd.temperature_sel;
                timer_reg <= conv_cycles;
                avail_reg <= 1'b0;
            end
            if (is_read) begin
                avail_reg <= 1'b0;
                if (busy_reg) begin
                    corrupt_reg <= 1'b1;
                end
            end
            if (finish && !(is_conv && !busy_reg)) begin
                // completion is a set: it beats a read clear in the same cycle
                busy_reg <= 1'b0;
                avail_reg <= 1'b1;
                corrupt_reg <= 1'b0;
                if (kind_reg) begin
                    result_reg <= raw_temperature_sample ^ (corrupt_reg ? CORRUPT_MASK : RESULT_ZERO);
                end else begin
                    result_reg <= raw_pressure_sample ^ (corrupt_reg ? CORRUPT_MASK : RESULT_ZERO);
                end
            end
        end
    end

    // readable level for the link, registered so it crosses as one flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readable_reg <= 1'b0;
            conv_busy <= 1'b0;
            conv_temperature <= 1'b0;
        end else begin
            readable_reg <= avail_reg && !busy_reg && !is_read;
            conv_busy <= busy_reg;
            conv_temperature <= kind_reg;
        end
    end

    // calibration memory: empty until the reset command loads it
    genvar w;
    generate
        for (w = 0; w < CAL_WORDS; w = w + 1) begin : g_cal
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    calib_reg[w] <= '0;
                end else if (is_reset) begin
                    // word 7 carries serial code and its 4-bit check in the low nibble
                    calib_reg[w] <= calib_fuse[w*CAL_WIDTH +: CAL_WIDTH];
                end
            end
        end
    endgenerate

    // link side
    // spi frames are cleared while chip select is high; clock may be stopped then
    assign link_clr = rst || (!i2c_mode_reg && chip_select_pin_n);

    // i2c start: data falls while the clock is high; toggles cross by protocol
    // timing, since the toggle settles a whole clock-low phase before the next rise
    always_ff @(negedge serial_data_in or posedge rst) begin
        if (rst) begin
            start_tgl_reg <= 1'b0;
        end else if (i2c_mode_reg && serial_clock) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // core status into the link clock: two flops
    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            stat_s1_reg <= '0;
            stat_s2_reg <= '0;
            start_seen_reg <= 1'b0;
        end else begin
            stat_s1_reg <= '{busy: busy_reg, readable: readable_reg};
            stat_s2_reg <= stat_s1_reg;
            start_seen_reg <= start_tgl_reg;
        end
    end

    assign start_evt = i2c_mode_reg && (start_tgl_reg != start_seen_reg);
    assign rx_byte = {rx_reg, serial_data_in};
    assign rx_cmd = bsp_cmd_type'(rx_byte);
    assign cmd_done = (state_reg == LK_CMD) && (bit_cnt_reg == BIT_LAST) && !start_evt;
    assign addr_hit = (rx_byte[7:1] == {I2C_ADDR_HI, addr_c_reg});

    // answer word chosen when the command byte completes
    always_comb begin
        cmd_word = RESULT_ZERO;
        if ((rx_byte[7:4] == CMD_MEM_HI) && !rx_cmd.stop) begin
            cmd_word = {calib_reg[rx_cmd.field], CAL_PAD};
        end else if (rx_byte == CMD_RESULT && stat_s2_reg.readable) begin
            cmd_word = result_reg;
        end
    end

    // command hand-off to the core; survives chip select so i2c reads see it
    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            cmd_tgl_reg <= 1'b0;
            cmd_byte_reg <= CMD_RESULT;
            held_word_reg <= RESULT_ZERO;
        end else if (cmd_done) begin
            cmd_tgl_reg <= ~cmd_tgl_reg;
            cmd_byte_reg <= rx_byte;
            held_word_reg <= cmd_word;
        end
    end

    // frame state, sampled on the rising clock edge in both spi modes
    always_ff @(posedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            state_reg <= LK_CMD;
            bit_cnt_reg <= '0;
            rx_reg <= '0;
            tx_reg <= RESULT_ZERO;
            ack_reg <= 1'b0;
        end else if (start_evt) begin
            state_reg <= LK_ADDR;
            bit_cnt_reg <= BIT_FIRST;
            rx_reg <= {6'h00, serial_data_in};
            ack_reg <= 1'b0;
        end else if (bit_cnt_reg == I2C_ACK_SLOT) begin
            bit_cnt_reg <= '0;
            ack_reg <= 1'b0;
            if (state_reg == LK_SEND && serial_data_in) begin
                state_reg <= LK_DONE;
            end
        end else if (state_reg == LK_SEND) begin
            tx_reg <= {tx_reg[22:0], 1'b0};
            if (i2c_mode_reg) begin
                bit_cnt_reg <= bit_cnt_reg + BIT_FIRST;
            end
        end else if (bit_cnt_reg == BIT_LAST) begin
            bit_cnt_reg <= i2c_mode_reg ? I2C_ACK_SLOT : 4'h0;
            case (state_reg)
                LK_ADDR: begin
                    if (!addr_hit) begin
                        state_reg <= LK_DONE;
                    end else if (!rx_byte[0]) begin
                        ack_reg <= 1'b1;
                        state_reg <= LK_CMD;
                    end else if (!stat_s2_reg.busy) begin
                        ack_reg <= 1'b1;
                        state_reg <= LK_SEND;
                        tx_reg <= held_word_reg;
                    end else begin
                        // still converting: refuse the read address
                        state_reg <= LK_DONE;
                    end
                end
                LK_CMD: begin
                    ack_reg <= i2c_mode_reg;
                    if (i2c_mode_reg) begin
                        state_reg <= LK_DONE;
                    end else begin
                        state_reg <= LK_SEND;
                        tx_reg <= cmd_word;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end else begin
            rx_reg <= rx_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + BIT_FIRST;
        end
    end

    // outputs change on the falling edge so the host samples a settled bit
    assign drive_low = i2c_mode_reg && (((bit_cnt_reg == I2C_ACK_SLOT) && ack_reg)
        || ((state_reg == LK_SEND) && (bit_cnt_reg < I2C_ACK_SLOT) && !tx_reg[23]));

    always_ff @(negedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            out_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            out_reg <= !i2c_mode_reg && (state_reg == LK_SEND) && tx_reg[23];
            oe_n_reg <= i2c_mode_reg ? !drive_low : 1'b0;
        end
    end

    assign serial_data_out = out_reg;
    assign serial_data_oe_n = oe_n_reg;

endmodule : bsp_serial_port

// ### sim/bsp_serial_port_asserts.sv
// concurrent checks on the serial port pins and the conversion status
`timescale 1ns/100ps
module bsp_serial_port_checker import bsp_pkg::*; #(
    parameter int CONV_CYCLES_PER_SAMPLE = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic chip_select_pin_n,
    input wire logic protocol_select_i2c,
    input wire logic serial_data_oe_n,
    input wire logic conv_busy,
    input wire logic conv_temperature
);
    localparam int CONV_UNIT = 256 * CONV_CYCLES_PER_SAMPLE;
    int busy_cnt;
    // length of the running conversion, so its end can be judged against the ratio table
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= conv_busy ? busy_cnt + 1 : 0;
        end
    end
    sequence s_busy_start;
        $rose(conv_busy);
    endsequence
    sequence s_busy_hold;
        conv_busy [*8];
    endsequence
    property p_busy_hold;
        @(posedge clock) disable iff (rst) s_busy_start |-> s_busy_hold;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("conversion ended too soon");
    property p_busy_len;
        @(posedge clock) disable iff (rst) $fell(conv_busy) |->
            busy_cnt inside {CONV_UNIT, 2*CONV_UNIT, 4*CONV_UNIT, 8*CONV_UNIT, 16*CONV_UNIT};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion length off");
    property p_busy_bound;
        @(posedge clock) disable iff (rst) conv_busy |-> busy_cnt < 16 * CONV_UNIT;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("conversion overran");
    property p_temp_stable;
        @(posedge clock) disable iff (rst) conv_busy [*3] |-> $stable(conv_temperature);
    endproperty
    a_temp_stable: assert property (p_temp_stable) else $error("kind changed mid conversion");
    property p_reset_quiet;
        @(posedge clock) disable iff (rst) $fell(rst) |-> serial_data_oe_n && !conv_busy;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("not idle after reset");
    property p_cs_release;
        @(posedge clock) disable iff (rst)
            !protocol_select_i2c && chip_select_pin_n [*2] |-> serial_data_oe_n;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("output on while deselected");
    property p_oe_link;
        @(posedge serial_clock) disable iff (rst)
            !protocol_select_i2c && !serial_data_oe_n |-> !chip_select_pin_n;
    endproperty
    a_oe_link: assert property (p_oe_link) else $error("output on at link edge without select");
    property p_oe_start;
        @(posedge clock) disable iff (rst)
            $fell(serial_data_oe_n) && !protocol_select_i2c |-> !chip_select_pin_n;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("output enabled outside a frame");
endmodule : bsp_serial_port_checker

bind bsp_serial_port bsp_serial_port_checker #(
    .CONV_CYCLES_PER_SAMPLE(CONV_CYCLES_PER_SAMPLE)
) i_checker (
    .clock(clock), .rst(rst), .serial_clock(serial_clock),
    .chip_select_pin_n(chip_select_pin_n), .protocol_select_i2c(protocol_select_i2c),
    .serial_data_oe_n(serial_data_oe_n), .conv_busy(conv_busy),
    .conv_temperature(conv_temperature)
);

// ### sim/bsp_host_model.sv
// host controller model: spi master in mode 0 or 3, or i2c master, 80 ns link clock
`timescale 1ns/100ps
module bsp_host_model (
    output logic serial_clock,
    output logic serial_data_in,
    output logic chip_select_pin_n,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    input wire logic i2c,
    output logic [23:0] rx_data,
    output logic rx_valid
);
    logic sda;
    // i2c data is open drain with a pull-up: the device can only pull it low
    assign serial_data_in = sda & (serial_data_oe_n | !i2c);
    initial begin
        serial_clock = 1'b0;
        sda = 1'b1;
        chip_select_pin_n = 1'b1;
        rx_data = 24'h000000;
        rx_valid = 1'b0;
    end
    // the link clock toggles only inside a frame; before chip select falls it is set to its idle level cpol
    task automatic xfer(input logic [7:0] cmd, input bit rd, input bit cpol);
        logic [23:0] got;
        got = 24'h000000;
        serial_clock = cpol;
        #40 chip_select_pin_n = 1'b0;
        #40;
        for (int i = 0; i < (rd ? 32 : 8); i++) begin
            serial_clock = 1'b0;
            // data line toggles once the command is out, so stale bits never look valid
            sda = (i < 8) ? cmd[7 - i] : ~sda;
            #40;
            if (i >= 8) begin
                got = {got[22:0], serial_data_oe_n ? 1'bx : serial_data_out};
            end
            serial_clock = 1'b1;
            #40;
        end
        serial_clock = cpol;
        #40 chip_select_pin_n = 1'b1;
        sda = ~sda;
        if (rd) begin
            rx_data = got;
            rx_valid = 1'b1;
            #1 rx_valid = 1'b0;
        end
    endtask : xfer

    // chip select is a strap in i2c: held low, so the address bit c is one
    task automatic i2c_start;
        chip_select_pin_n = 1'b0;
        serial_clock = 1'b0;
        sda = 1'b1;
        #20 serial_clock = 1'b1;
        #20 sda = 1'b0;
        #20 serial_clock = 1'b0;
    endtask : i2c_start

    task automatic i2c_stop;
        sda = 1'b0;
        #20 serial_clock = 1'b1;
        #20 sda = 1'b1;
        #20;
    endtask : i2c_stop

    // data changes only while the clock is low; sampled in the high phase
    task automatic i2c_bit(input logic b, output logic got);
        sda = b;
        #20 serial_clock = 1'b1;
        #20 got = serial_data_in;
        #20 serial_clock = 1'b0;
        #20;
    endtask : i2c_bit

    // nbytes 0: write addr_byte then cmd; otherwise read nbytes after addr_byte
    task automatic i2c_xfer(input logic [7:0] addr_byte, input logic [7:0] cmd,
                            input int nbytes);
        logic [23:0] got;
        logic b;
        got = 24'h000000;
        i2c_start();
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(addr_byte[i], b);
        end
        i2c_bit(1'b1, b);
        if (nbytes == 0) begin
            for (int i = 7; i >= 0; i--) begin
                i2c_bit(cmd[i], b);
            end
            i2c_bit(1'b1, b);
        end
        for (int n = 0; n < nbytes; n++) begin
            for (int i = 0; i < 8; i++) begin
                i2c_bit(1'b1, b);
                got = {got[22:0], b};
            end
            i2c_bit(n == nbytes - 1, b);
        end
        i2c_stop();
        if (nbytes > 0) begin
            rx_data = got;
            rx_valid = 1'b1;
            #1 rx_valid = 1'b0;
        end
    endtask : i2c_xfer
endmodule : bsp_host_model

// ### sim/testbench.sv
// self-checking bench for the serial command port on its spi and i2c sides
`timescale 1ns/100ps
module testbench;
    import bsp_pkg::*;
    localparam int CPS = 1;
    logic clock, rst, serial_clock, serial_data_in, chip_select_pin_n;
    logic protocol_select_i2c, serial_data_out, serial_data_oe_n;
    logic conv_busy, conv_temperature, rx_valid;
    logic [127:0] calib_fuse;
    logic [23:0] raw_pressure_sample, raw_temperature_sample, rx_data, conv_exp;
    logic [15:0] word;
    logic [23:0] expect_q[$];
    int miscompares = 0;
    int checks_done = 0;

    bsp_serial_port #(.CONV_CYCLES_PER_SAMPLE(CPS)) i_dut (
        .clock(clock), .rst(rst), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .chip_select_pin_n(chip_select_pin_n),
        .protocol_select_i2c(protocol_select_i2c), .calib_fuse(calib_fuse),
        .raw_pressure_sample(raw_pressure_sample),
        .raw_temperature_sample(raw_temperature_sample),
        .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
        .conv_busy(conv_busy), .conv_temperature(conv_temperature)
    );
    bsp_host_model i_host (
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .chip_select_pin_n(chip_select_pin_n), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .i2c(protocol_select_i2c),
        .rx_data(rx_data), .rx_valid(rx_valid)
    );

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // each finished read frame is matched to the oldest noted expectation
    always @(posedge rx_valid) begin
        check("frame data", expect_q.pop_front(), rx_data);
    end

    // the pause after a frame lets the core see the command before the next one
    task automatic send(input logic [7:0] cmd, input logic [23:0] exp, input bit rd, cpol);
        if (rd) begin
            expect_q.push_back(exp);
        end
        i_host.xfer(cmd, rd, cpol);
        repeat (10) @(negedge clock);
    endtask : send

    task automatic i2c_send(input logic [7:0] addr_byte, input logic [7:0] cmd,
                            input int nbytes, input logic [23:0] exp);
        if (nbytes > 0) begin
            expect_q.push_back(exp);
        end
        i_host.i2c_xfer(addr_byte, cmd, nbytes);
        repeat (10) @(negedge clock);
    endtask : i2c_send

    task automatic wait_idle;
        int n;
        n = 0;
        while (conv_busy !== 1'b0 && n < 5000) begin
            @(negedge clock);
            n++;
        end
        check("conversion end", 24'h0, {23'h0, conv_busy});
    endtask : wait_idle

    task automatic start_conv(input bit temp, input logic [2:0] idx, input bit cpol);
        raw_pressure_sample = 24'($urandom);
        raw_temperature_sample = 24'($urandom);
        conv_exp = temp ? raw_temperature_sample : raw_pressure_sample;
        if (protocol_select_i2c) begin
            i2c_send({I2C_ADDR_HI, 2'b10}, {CMD_CONV_HI, temp, idx, 1'b0}, 0, RESULT_ZERO);
        end else begin
            send({CMD_CONV_HI, temp, idx, 1'b0}, RESULT_ZERO, 1'b0, cpol);
        end
        check("busy", 24'h1, {23'h0, conv_busy});
        check("kind", {23'h0, temp}, {23'h0, conv_temperature});
    endtask : start_conv

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        #2000000;
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        rst = 1'b1;
        protocol_select_i2c = 1'b0;
        void'($urandom(80));
        calib_fuse = {$urandom, $urandom, $urandom, $urandom};
        raw_pressure_sample = 24'h000000;
        raw_temperature_sample = 24'h000000;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        repeat (6) @(negedge clock);
        send({CMD_MEM_HI, 3'h3, 1'b0}, 24'h000000, 1'b1, 1'b0);
        $display("memory before load done");
        send(CMD_RESET, RESULT_ZERO, 1'b0, 1'b1);
        for (int w = 0; w < CAL_WORDS; w++) begin
            word = calib_fuse[16*w +: 16];
            send({CMD_MEM_HI, 3'(w), 1'b0}, {word, CAL_PAD}, 1'b1, w[0]);
        end
        $display("calibration memory done");
        send(CMD_RESULT, RESULT_ZERO, 1'b1, 1'b0);
        for (int k = 0; k <= OSR_MAX_IDX; k++) begin
            start_conv(k[0], 3'(k), k[1]);
            wait_idle();
            send(CMD_RESULT, conv_exp, 1'b1, k[0]);
            send(CMD_RESULT, RESULT_ZERO, 1'b1, 1'b1);
            $display("conversion with ratio index %0d done", k);
        end
        start_conv(1'b0, OSR_MAX_IDX, 1'b1);
        send(CMD_RESULT, RESULT_ZERO, 1'b1, 1'b0);
        wait_idle();
        send(CMD_RESULT, conv_exp ^ CORRUPT_MASK, 1'b1, 1'b1);
        $display("read during conversion done");
        // address 111011 with c one, since the model straps chip select low
        protocol_select_i2c = 1'b1;
        repeat (10) @(negedge clock);
        i2c_send({I2C_ADDR_HI, 2'b10}, {CMD_MEM_HI, 3'h3, 1'b0}, 0, RESULT_ZERO);
        i2c_send({I2C_ADDR_HI, 2'b11}, CMD_RESULT, 2, {8'h00, calib_fuse[63:48]});
        start_conv(1'b1, OSR_MAX_IDX, 1'b0);
        i2c_send({I2C_ADDR_HI, 2'b11}, CMD_RESULT, 3, 24'hffffff);
        wait_idle();
        i2c_send({I2C_ADDR_HI, 2'b10}, CMD_RESULT, 0, RESULT_ZERO);
        i2c_send({I2C_ADDR_HI, 2'b11}, CMD_RESULT, 3, conv_exp);
        i2c_send({I2C_ADDR_HI, 2'b10}, CMD_RESULT, 0, RESULT_ZERO);
        i2c_send({I2C_ADDR_HI, 2'b11}, CMD_RESULT, 3, RESULT_ZERO);
        $display("i2c transfers done");
        complete_run();
    end
endmodule : testbench
